// [design/scmsw_pkg.sv]
// Shared constants and types for the system call and mode switch block.
// Assumes a 32-bit byte-addressed memory holding the procedure table.
package scmsw_pkg;

  // Widths
  localparam int PROC_W = 8;

  // Table layout, byte offsets from the table base
  localparam logic [31:0] SSP_OFF = 32'h0000000c;
  localparam logic [31:0] ENT_BASE_OFF = 32'h00000030;

  // Field positions inside table words
  localparam int ENT_TYPE_LSB = 0;
  localparam int TRACE_BIT = 0;

  // Entry type encodings
  localparam logic [1:0] ENT_LOCAL = 2'h0;
  localparam logic [1:0] ENT_SUP = 2'h2;

  // Return status codes in the previous frame word
  localparam logic [2:0] RS_LOCAL = 3'h0;
  localparam logic [2:0] RS_SUP = 3'h2;

  // Word alignment and 64-byte frame rounding
  localparam logic [31:0] WORD_MASK = 32'hfffffffc;
  localparam logic [31:0] FP_ROUND = 32'h0000003f;

  // Mode encodings and reset values
  localparam logic MODE_SUP = 1'b1;
  localparam logic MODE_USER = 1'b0;
  localparam logic TRACE_RST = 1'b0;
  localparam logic [31:0] BASE_RST = 32'h00000000;

  // Operations offered to the sequencer
  typedef enum logic [1:0] {
    OP_CALL_REL,
    OP_CALLS,
    OP_RET,
    OP_MODPC
  } scmsw_op_t;

endpackage

// [design/scmsw_rd_if.sv]
// Word read request channel between the sequencer and its fetch unit.
// Both ends sit on the same clock.
`timescale 1ns/1ps
interface scmsw_rd_if;
  logic req;
  logic [31:0] addr;
  logic done;
  logic [31:0] data;

  modport user (output req, output addr, input done, input data);
  modport fetcher (input req, input addr, output done, output data);
endinterface

// [design/scmsw_word_fetch.sv]
// Word fetch unit: turns a held request into one memory read.
// Assumes the memory answers on the same clock with a one-cycle ack.
`timescale 1ns/1ps
module scmsw_word_fetch
  import scmsw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  scmsw_rd_if.fetcher rd,
  output logic mem_rd_req,
  output logic [31:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [31:0] mem_rd_data
);

  typedef enum logic [1:0] {F_IDLE, F_WAIT, F_HOLD} scmsw_fst_t;

  scmsw_fst_t st_q, st_d;
  logic [31:0] addr_q, addr_d;
  logic [31:0] data_q, data_d;

  // Next state; HOLD gives the requester one cycle to drop or move on
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    data_d = data_q;
    case (st_q)
      F_IDLE: begin
        if (rd.req) begin
          st_d = F_WAIT;
          addr_d = rd.addr & WORD_MASK;
        end
      end
      F_WAIT: begin
        if (mem_rd_ack) begin
          st_d = F_HOLD;
          data_d = mem_rd_data;
        end
      end
      default: st_d = F_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= F_IDLE;
      addr_q <= 32'h00000000;
      data_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  // Outputs
  assign mem_rd_req = (st_q == F_WAIT);
  assign mem_rd_addr = addr_q;
  assign rd.done = (st_q == F_HOLD);
  assign rd.data = data_q;

endmodule

// [design/scmsw_ctrl.sv]
// Call sequencer for table calls, returns and the privileged mode write.
// Assumes one command at a time from the core and a synchronous memory.
`timescale 1ns/1ps
// What this block does
// - Table base comes from startup memory image
// - Procedure number indexes the table entry
// - Target address low two bits forced zero
// - Entry type 00 local, 10 supervisor
// - Supervisor stack pointer from table byte offset 12
// - Trace flag loaded from table bit 0
// - Local entry: plain call, no switches
// - Return status 000 gives plain local return
// - User to supervisor call writes status 01X
// - Supervisor held until switching call returns or a mode write clears it
// - Relative calls never switch stack or mode
// - Status 01X return goes back to user
// - Table stack pointer rounded up to 64
// - Supervisor nested call rounds current SP
// - Mode write allowed in supervisor only
// - Reset enters supervisor mode
// - Supervisor kept until mode write or status 01X return clears it
// - Single stack uses return pointer register
// - Mode never shown on any pin
module scmsw_ctrl
  import scmsw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic table_base_load,
  input wire logic [31:0] startup_memory_image_base,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire scmsw_op_t cmd_op,
  input wire logic [PROC_W-1:0] cmd_proc_num,
  input wire logic [31:0] cmd_target_ip,
  input wire logic [31:0] cmd_cur_sp,
  input wire logic [31:0] previous_frame_local_reg,
  input wire logic [31:0] return_pointer_local_reg,
  input wire logic cmd_mode_mask,
  input wire logic cmd_mode_val,
  output logic mem_rd_req,
  output logic [31:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [31:0] mem_rd_data,
  output logic rsp_valid,
  output logic [31:0] rsp_target_ip,
  output logic [31:0] rsp_new_fp,
  output logic [2:0] rsp_status,
  output logic rsp_to_sup_stack,
  output logic rsp_to_local_stack,
  output logic rsp_fault_reserved,
  output logic rsp_fault_priv,
  output logic trace_enable
);

  typedef enum logic [1:0] {S_IDLE, S_ENT_RD, S_SSP_RD} scmsw_st_t;

  // Round a stack pointer up to the next 64-byte frame boundary
  function automatic logic [31:0] align_fp(input logic [31:0] sp);
    align_fp = (sp + FP_ROUND) & ~FP_ROUND;
  endfunction

  scmsw_rd_if rd ();

  scmsw_st_t st_q, st_d;
  logic mode_sup_q, mode_sup_d;
  logic single_q, single_d;
  logic trace_q, trace_d;
  logic [31:0] base_q, base_d;
  logic [31:0] sp_q, sp_d;
  logic valid_q, valid_d;
  logic [31:0] tgt_q, tgt_d;
  logic [31:0] fp_q, fp_d;
  logic [2:0] stat_q, stat_d;
  logic to_sup_q, to_sup_d;
  logic to_loc_q, to_loc_d;
  logic fres_q, fres_d;
  logic fpriv_q, fpriv_d;

  logic cmd_fire;
  logic [31:0] frame_sp;
  logic [1:0] ent_type;

  assign cmd_ready = (st_q == S_IDLE);
  assign cmd_fire = cmd_valid && cmd_ready;
  // Single-stack supervisor code keeps its stack pointer elsewhere
  assign frame_sp = (mode_sup_q && single_q) ?
                    return_pointer_local_reg : cmd_cur_sp;
  assign ent_type = rd.data[ENT_TYPE_LSB +: 2];

  // Table reads: entry word, then supervisor stack word
  assign rd.req = (st_q != S_IDLE);
  assign rd.addr = (st_q == S_SSP_RD) ? (base_q + SSP_OFF) :
                   (base_q + ENT_BASE_OFF +
                    32'({cmd_proc_num, 2'h0}));

  scmsw_word_fetch u_fetch (
    .clk(clk),
    .rst(rst),
    .rd(rd),
    .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr),
    .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data)
  );

  // Sequencer, mode state and answer computation
  always_comb begin
    st_d = st_q;
    mode_sup_d = mode_sup_q;
    single_d = single_q;
    trace_d = trace_q;
    base_d = base_q;
    sp_d = sp_q;
    valid_d = 1'b0;
    tgt_d = tgt_q;
    fp_d = fp_q;
    stat_d = stat_q;
    to_sup_d = 1'b0;
    to_loc_d = 1'b0;
    fres_d = 1'b0;
    fpriv_d = 1'b0;
    if (table_base_load) begin
      base_d = startup_memory_image_base & WORD_MASK;
    end
    case (st_q)
      S_IDLE: begin
        if (cmd_fire) begin
          sp_d = frame_sp;
          case (cmd_op)
            OP_CALLS: st_d = S_ENT_RD;
            OP_CALL_REL: begin
              // Same mode, same stack, current frame rounded
              valid_d = 1'b1;
              tgt_d = cmd_target_ip & WORD_MASK;
              fp_d = align_fp(frame_sp);
              stat_d = RS_LOCAL;
            end
            OP_RET: begin
              valid_d = 1'b1;
              stat_d = previous_frame_local_reg[2:0];
              if (previous_frame_local_reg[2:1] == RS_SUP[2:1] &&
                  mode_sup_q) begin
                mode_sup_d = MODE_USER;
                to_loc_d = 1'b1;
              end
              // Any other status returns with no switch
            end
            default: begin
              valid_d = 1'b1;
              if (!mode_sup_q) begin
                fpriv_d = 1'b1;
              end else if (cmd_mode_mask) begin
                mode_sup_d = cmd_mode_val;
                if (cmd_mode_val == MODE_USER) begin
                  single_d = 1'b0;
                end
              end
            end
          endcase
        end
      end
      S_ENT_RD: begin
        if (rd.done) begin
          tgt_d = rd.data & WORD_MASK;
          stat_d = RS_LOCAL;
          if (ent_type == ENT_LOCAL ||
              (ent_type == ENT_SUP && mode_sup_q)) begin
            // Plain call, nested supervisor call likewise
            st_d = S_IDLE;
            valid_d = 1'b1;
            fp_d = align_fp(sp_q);
          end else if (ent_type == ENT_SUP) begin
            st_d = S_SSP_RD;
          end else begin
            // Reserved type: no call, no state change
            st_d = S_IDLE;
            valid_d = 1'b1;
            fres_d = 1'b1;
          end
        end
      end
      S_SSP_RD: begin
        if (rd.done) begin
          st_d = S_IDLE;
          valid_d = 1'b1;
          mode_sup_d = MODE_SUP;
          single_d = 1'b0;
          trace_d = rd.data[TRACE_BIT];
          fp_d = align_fp(rd.data & WORD_MASK);
          stat_d = RS_SUP;
          to_sup_d = 1'b1;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // Registers; reset starts in supervisor, single stack
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      mode_sup_q <= MODE_SUP;
      single_q <= 1'b1;
      trace_q <= TRACE_RST;
      base_q <= BASE_RST;
      sp_q <= 32'h00000000;
      valid_q <= 1'b0;
      tgt_q <= 32'h00000000;
      fp_q <= 32'h00000000;
      stat_q <= RS_LOCAL;
      to_sup_q <= 1'b0;
      to_loc_q <= 1'b0;
      fres_q <= 1'b0;
      fpriv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_sup_q <= mode_sup_d;
      single_q <= single_d;
      trace_q <= trace_d;
      base_q <= base_d;
      sp_q <= sp_d;
      valid_q <= valid_d;
      tgt_q <= tgt_d;
      fp_q <= fp_d;
      stat_q <= stat_d;
      to_sup_q <= to_sup_d;
      to_loc_q <= to_loc_d;
      fres_q <= fres_d;
      fpriv_q <= fpriv_d;
    end
  end

  // Answer outputs; the mode bit itself stays inside
  assign rsp_valid = valid_q;
  assign rsp_target_ip = tgt_q;
  assign rsp_new_fp = fp_q;
  assign rsp_status = stat_q;
  assign rsp_to_sup_stack = to_sup_q;
  assign rsp_to_local_stack = to_loc_q;
  assign rsp_fault_reserved = fres_q;
  assign rsp_fault_priv = fpriv_q;
  assign trace_enable = trace_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ent_user_sup;
    st_q == S_ENT_RD && rd.done && ent_type == ENT_SUP && !mode_sup_q;
  endsequence

  sequence s_ssp_arrives;
    st_q == S_SSP_RD && rd.done;
  endsequence

  sequence s_ent_reserved;
    st_q == S_ENT_RD && rd.done && ent_type[0];
  endsequence

  a_reset_sup_mode: assert property (
    $past(rst) |-> mode_sup_q && single_q)
    else $error("mode not supervisor after reset");

  a_reserved_faults: assert property (
    s_ent_reserved |=> rsp_valid && rsp_fault_reserved &&
      !rsp_to_sup_stack && $stable(mode_sup_q))
    else $error("reserved entry type not faulted");

  a_user_sup_call: assert property (
    s_ent_user_sup |=> ##[2:40] s_ssp_arrives ##1
      (mode_sup_q && rsp_to_sup_stack && rsp_status == RS_SUP))
    else $error("supervisor call did not switch");

  a_trace_from_tbl: assert property (
    s_ssp_arrives |=> trace_enable == $past(rd.data[TRACE_BIT]) &&
      rsp_new_fp == align_fp($past(rd.data) & WORD_MASK))
    else $error("trace or frame pointer wrong on switch");

  a_call_aligned: assert property (
    st_q == S_ENT_RD && rd.done && ent_type == ENT_LOCAL |=>
      rsp_valid && rsp_target_ip[1:0] == 2'h0 &&
      rsp_target_ip[31:2] == $past(rd.data[31:2]))
    else $error("target address not word aligned");

  a_rel_no_switch: assert property (
    cmd_fire && cmd_op == OP_CALL_REL |=> rsp_valid &&
      !rsp_to_sup_stack && $stable(mode_sup_q) &&
      rsp_new_fp[5:0] == 6'h00)
    else $error("relative call changed mode");

  a_sup_return: assert property (
    cmd_fire && cmd_op == OP_RET && mode_sup_q &&
      previous_frame_local_reg[2:1] == RS_SUP[2:1] |=>
      !mode_sup_q && rsp_to_local_stack)
    else $error("supervisor return did not reach user");

  a_local_return: assert property (
    cmd_fire && cmd_op == OP_RET &&
      previous_frame_local_reg[2:0] == RS_LOCAL |=>
      $stable(mode_sup_q) && !rsp_to_local_stack)
    else $error("local return switched");

  a_modpc_priv: assert property (
    cmd_fire && cmd_op == OP_MODPC && !mode_sup_q |=>
      rsp_fault_priv && !mode_sup_q)
    else $error("mode write allowed in user mode");

  a_sup_held: assert property (
    mode_sup_q && !(cmd_fire && (cmd_op == OP_RET ||
      cmd_op == OP_MODPC)) |=> mode_sup_q)
    else $error("supervisor mode left without cause");

endmodule

// [bench/scmsw_mem_model.sv]
// Behavioural memory holding the procedure table and stack words.
// Assumes the same clock as the sequencer and one read at a time.
`timescale 1ns/1ps
module scmsw_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  output logic mem_rd_ack,
  output logic [31:0] mem_rd_data
);
  logic [31:0] mem [0:1023];
  int lat = 0;
  int cnt = 0;

  initial begin
    mem_rd_ack = 1'b0;
    mem_rd_data = 32'h5a5a5a5a;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 32'h00000000;
    end
  end

  // One-cycle ack after lat wait cycles; data scrambled outside the ack
  always @(posedge clk) begin
    #1;
    if (rst) begin
      mem_rd_ack = 1'b0;
      cnt = 0;
    end else if (mem_rd_ack) begin
      mem_rd_ack = 1'b0;
      mem_rd_data = ~mem_rd_data;
      cnt = 0;
    end else if (mem_rd_req) begin
      if (cnt >= lat) begin
        mem_rd_ack = 1'b1;
        mem_rd_data = mem[mem_rd_addr[11:2]];
      end else begin
        cnt++;
      end
    end
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the call sequencer and its memory model.
// Assumes scmsw_ctrl is the top and answers one command at a time.
`timescale 1ns/1ps
module testbench;
  import scmsw_pkg::*;
  logic clk = 1'b0, rst = 1'b1, table_base_load = 1'b0, cmd_valid = 1'b0;
  logic [31:0] base_in = '0, tip = '0, sp = '0, pfl = '0, rpl = '0;
  logic [PROC_W-1:0] pn = '0;
  logic m = 1'b0, v = 1'b0, cmd_ready, mem_rd_req, mem_rd_ack, rsp_valid;
  logic [31:0] mem_rd_addr, mem_rd_data, rsp_target_ip, rsp_new_fp;
  logic [2:0] rsp_status;
  logic to_sup, to_loc, f_res, f_priv, trace_enable;
  logic [31:0] fl;
  scmsw_op_t op = OP_RET;
  int n_mismatch = 0, checked = 0;

  always #10 clk = ~clk;

  scmsw_ctrl i_scmsw_ctrl (.clk(clk), .rst(rst),
    .table_base_load(table_base_load), .startup_memory_image_base(base_in),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(op),
    .cmd_proc_num(pn), .cmd_target_ip(tip), .cmd_cur_sp(sp),
    .previous_frame_local_reg(pfl), .return_pointer_local_reg(rpl),
    .cmd_mode_mask(m), .cmd_mode_val(v), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data), .rsp_valid(rsp_valid),
    .rsp_target_ip(rsp_target_ip), .rsp_new_fp(rsp_new_fp),
    .rsp_status(rsp_status), .rsp_to_sup_stack(to_sup),
    .rsp_to_local_stack(to_loc), .rsp_fault_reserved(f_res),
    .rsp_fault_priv(f_priv), .trace_enable(trace_enable));

  scmsw_mem_model i_scmsw_mem_model (.clk(clk), .rst(rst),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));

  // Compare and count
  task automatic chk(input string name, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // One command; pulse flags captured in the answer cycle
  task automatic issue(input scmsw_op_t o, input int n,
                       input logic [31:0] t, s, p, r, input logic mm, vv);
    int i;
    op = o; pn = PROC_W'(n); tip = t; sp = s;
    pfl = p; rpl = r; m = mm; v = vv;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 40) begin
      @(posedge clk);
      #1 i++;
    end
    if (i >= 40) chk("rsp_valid", 1, 0);
    fl = {28'h0, to_sup, to_loc, f_res, f_priv};
    @(posedge clk);
    #1;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200000;
    chk("watchdog", 1, 0);
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clk);
    // Table written after the model has cleared its storage at time 0
    // Entries: local 3, supervisor 5, reserved 6 and 7, then stack word
    i_scmsw_mem_model.mem[(12'h13c) >> 2] = 32'h00004a40;
    i_scmsw_mem_model.mem[(12'h144) >> 2] = 32'h00008002;
    i_scmsw_mem_model.mem[(12'h148) >> 2] = 32'h00009001;
    i_scmsw_mem_model.mem[(12'h14c) >> 2] = 32'h00009003;
    i_scmsw_mem_model.mem[(12'h10c) >> 2] = 32'h00007105;
    #1 rst = 1'b0;
    chk("trace_rst", 0, {31'h0, trace_enable});
    chk("ready_rst", 1, {31'h0, cmd_ready});
    issue(OP_MODPC, 0, 0, 0, 0, 0, 1'b0, 1'b0);
    chk("modpc_reset", 0, fl);
    base_in = 32'h00000103;
    table_base_load = 1'b1;
    @(posedge clk);
    #1 table_base_load = 1'b0;
    $display("test reset done");
    issue(OP_CALLS, 3, 0, 0, 0, 32'h1004, 1'b0, 1'b0);
    chk("local_target", 32'h4a40, rsp_target_ip);
    chk("single_fp", 32'h1040, rsp_new_fp);
    chk("local_stat", 0, {29'h0, rsp_status});
    chk("local_fl", 0, fl);
    issue(OP_CALL_REL, 0, 32'h3007, 0, 0, 32'h2040, 1'b0, 1'b0);
    chk("rel_target", 32'h3004, rsp_target_ip);
    chk("rel_fp", 32'h2040, rsp_new_fp);
    chk("rel_fl", 0, fl);
    $display("test supervisor calls done");
    issue(OP_MODPC, 0, 0, 0, 0, 0, 1'b1, 1'b0);
    chk("to_user", 0, fl);
    issue(OP_MODPC, 0, 0, 0, 0, 0, 1'b1, 1'b1);
    chk("priv", 1, fl);
    issue(OP_CALL_REL, 0, 32'h3008, 32'h5008, 0, 0, 1'b0, 1'b0);
    chk("user_rel_fp", 32'h5040, rsp_new_fp);
    chk("user_rel_fl", 0, fl);
    for (int k = 6; k < 8; k++) begin
      issue(OP_CALLS, k, 0, 32'h6000, 0, 0, 1'b0, 1'b0);
      chk("reserved", 2, fl);
    end
    issue(OP_CALLS, 3, 0, 32'h6000, 0, 0, 1'b0, 1'b0);
    chk("user_local_fp", 32'h6000, rsp_new_fp);
    chk("user_local_fl", 0, fl);
    $display("test user mode done");
    i_scmsw_mem_model.lat = 3;
    issue(OP_CALLS, 5, 0, 32'h6000, 0, 0, 1'b0, 1'b0);
    chk("sup_target", 32'h8000, rsp_target_ip);
    chk("sup_fp", 32'h7140, rsp_new_fp);
    chk("sup_stat", 2, {29'h0, rsp_status});
    chk("sup_trace", 1, {31'h0, trace_enable});
    chk("sup_fl", 8, fl);
    i_scmsw_mem_model.lat = 0;
    issue(OP_CALLS, 3, 0, 32'h7184, 0, 0, 1'b0, 1'b0);
    chk("nest_fp", 32'h71c0, rsp_new_fp);
    chk("nest_fl", 0, fl);
    issue(OP_MODPC, 0, 0, 0, 0, 0, 1'b0, 1'b0);
    chk("still_sup", 0, fl);
    $display("test supervisor switch done");
    issue(OP_RET, 0, 0, 0, 32'h00000000, 0, 1'b0, 1'b0);
    chk("ret_local", 0, fl);
    issue(OP_RET, 0, 0, 0, 32'h00000003, 0, 1'b0, 1'b0);
    chk("ret_sup", 4, fl);
    chk("ret_stat", 3, {29'h0, rsp_status});
    issue(OP_MODPC, 0, 0, 0, 0, 0, 1'b1, 1'b1);
    chk("back_user", 1, fl);
    $display("test returns done");
    complete_run();
  end
endmodule
